// >>> common/wdt_pkg.sv
package wdt_pkg;

   // ***************************************************************
   // Register bus
   // ***************************************************************
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

   // ***************************************************************
   // Control/status fields
   // ***************************************************************
   localparam int unsigned RUN_BIT     = 7;
   localparam int unsigned SEL_HI_BIT  = 5;
   localparam int unsigned SEL_LO_BIT  = 4;
   localparam int unsigned FLAG_BIT    = 3;
   localparam int unsigned CAUSE_BIT   = 2;
   localparam int unsigned RSTEN_BIT   = 1;
   localparam int unsigned RESTART_BIT = 0;
   localparam logic [1:0]  SEL_RESET   = 2'h0;

   // ***************************************************************
   // Counting
   // ***************************************************************
   localparam int unsigned CNT_W   = 26;
   localparam int unsigned EXP_0   = 17;
   localparam int unsigned EXP_1   = 20;
   localparam int unsigned EXP_2   = 23;
   localparam int unsigned EXP_3   = 26;
   localparam int unsigned GRACE_CLKS = 512;
   localparam int unsigned GRACE_W    = 10;
   localparam logic [GRACE_W-1:0] GRACE_LAST = GRACE_W'(GRACE_CLKS - 1);
   localparam int unsigned RESET_MCYCLES = 2;
   localparam int unsigned HOLD_W        = 8;

   typedef enum logic [1:0]
   {
      WDT_COUNTING  = 2'b00,
      WDT_GRACE     = 2'b01,
      WDT_RESETTING = 2'b10
   } wdt_phase_e;

   // Low bits that are all ones on the last clock of the interval
   function automatic logic [CNT_W-1:0] wdt_interval_mask
      (input logic [1:0] sel);
      logic [CNT_W-1:0] m;
      m = '0;
      unique case (sel)
         2'h0: m = CNT_W'((64'h1 << EXP_0) - 64'h1);
         2'h1: m = CNT_W'((64'h1 << EXP_1) - 64'h1);
         2'h2: m = CNT_W'((64'h1 << EXP_2) - 64'h1);
         2'h3: m = CNT_W'((64'h1 << EXP_3) - 64'h1);
      endcase
      return m;
   endfunction : wdt_interval_mask

   function automatic logic wdt_ctrl_hit(input logic [ADDR_W-1:0] a);
      return a == CTRL_ADDR;
   endfunction : wdt_ctrl_hit

endpackage : wdt_pkg

// >>> common/wdt_cnt_if.sv
`timescale 1ns/1ps
interface wdt_cnt_if;
   import wdt_pkg::*;
   logic       tick;
   logic       run;
   logic [1:0] sel;
   logic       restart_req;
   logic       hard_clear;
   logic       timeout;
   logic       restart_ack;
   logic       count_nonzero;

   modport ctl
   (
      output tick, run, sel, restart_req, hard_clear,
      input  timeout, restart_ack, count_nonzero
   );
   modport cnt
   (
      input  tick, run, sel, restart_req, hard_clear,
      output timeout, restart_ack, count_nonzero
   );
endinterface : wdt_cnt_if

// >>> design/wdt_counter.sv
`timescale 1ns/1ps
module wdt_counter
   import wdt_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Control side
   wdt_cnt_if.cnt   cif
);

   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] mask;
   logic             timeout_reg;
   logic             ack_reg;
   logic             at_last;

   assign mask    = wdt_interval_mask(cif.sel);
   assign at_last = (count_reg & mask) == mask;

   // ***************************************************************
   // Divider chain
   // ***************************************************************
   // Restart acts on a watchdog tick even when stopped, so a stopped
   // counter never goes non-zero and the restart bit stays up.
   always_ff @(posedge ref_clk)
   begin
      if (rst || cif.hard_clear)
         count_reg <= '0;
      else if (cif.tick && cif.restart_req)
         count_reg <= '0;
      else if (cif.tick && cif.run)
         count_reg <= count_reg + CNT_W'(1);
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst || cif.hard_clear)
         timeout_reg <= 1'b0;
      else
         timeout_reg <= cif.tick && cif.run && !cif.restart_req
                        && at_last;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         ack_reg <= 1'b0;
      else
         ack_reg <= cif.tick && cif.restart_req;
   end

   assign cif.timeout       = timeout_reg;
   assign cif.restart_ack   = ack_reg;
   assign cif.count_nonzero = |count_reg;

endmodule : wdt_counter

// >>> design/wdt_top.sv
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module wdt_top
   import wdt_pkg::*;
#(
   parameter int unsigned MC_CLKS = 4
)
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   // Configuration and unlock
   input  wire logic              counter_clock_source_select,
   input  wire logic              rc_osc_pin,
   input  wire logic              timed_access_open,
   // Interrupt
   input  wire logic              wdt_irq_enable,
   input  wire logic              global_irq_enable,
   output logic                   wdt_irq,
   // Reset sources and output
   input  wire logic              power_fail_rst,
   input  wire logic              ext_rst,
   output logic                   wdt_sys_reset
);

   localparam int unsigned HOLD_CLKS = RESET_MCYCLES * MC_CLKS;
   localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CLKS - 1);

   // ***************************************************************
   // Declarations
   // ***************************************************************
   wdt_cnt_if cif ();

   logic              rc_meta_reg;
   logic              rc_sync_reg;
   logic              rc_prev_reg;
   logic              tick_reg;
   logic              run_reg;
   logic [1:0]        sel_reg;
   logic              flag_reg;
   logic              cause_reg;
   logic              rsten_reg;
   logic              restart_reg;
   logic              restart_seen_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic              irq_reg;
   logic              sys_reset_reg;
   logic [GRACE_W-1:0] grace_reg;
   logic [HOLD_W-1:0] hold_reg;
   wdt_phase_e        phase_reg;
   wdt_phase_e        phase_next;
   logic              pwr_rst;
   logic              any_rst;
   logic              wr_hit;
   logic              rd_hit;
   logic              prot_wr;
   logic              wd_tick;
   logic              grace_done;
   logic              fire;
   logic              restart_done;
   logic              restart_take;
   logic [DATA_W-1:0] status_byte;

   // ***************************************************************
   // Reset and write qualifiers
   // ***************************************************************
   assign pwr_rst = rst || power_fail_rst;
   // External reset only clears the time-out flag; the fields stay
   assign any_rst = pwr_rst || ext_rst;
   assign wr_hit  = reg_wr && wdt_ctrl_hit(reg_addr);
   assign rd_hit  = reg_rd && wdt_ctrl_hit(reg_addr);
   // Writes without the unlock still reach the unprotected bits
   assign prot_wr = wr_hit && timed_access_open;

   // ***************************************************************
   // Watchdog clock source
   // ***************************************************************
   // The RC oscillator is foreign to ref_clk; only the second stage
   // and the third are looked at, so it turns into a one-cycle enable safely.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         rc_meta_reg <= 1'b0;
         rc_sync_reg <= 1'b0;
         rc_prev_reg <= 1'b0;
      end
      else
      begin
         rc_meta_reg <= rc_osc_pin;
         rc_sync_reg <= rc_meta_reg;
         rc_prev_reg <= rc_sync_reg;
      end
   end

   // High select runs from the CPU clock, low from the RC clock
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         tick_reg <= 1'b0;
      else if (counter_clock_source_select)
         tick_reg <= 1'b1;
      else
         tick_reg <= rc_sync_reg && !rc_prev_reg;
   end

   assign wd_tick = tick_reg;

   // ***************************************************************
   // Counter link
   // ***************************************************************
   assign cif.tick        = wd_tick;
   assign cif.run         = run_reg;
   assign cif.sel         = sel_reg;
   assign cif.restart_req = restart_reg && !restart_seen_reg;
   assign cif.hard_clear  = pwr_rst || (phase_reg == WDT_RESETTING);

   wdt_counter u_counter
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .cif     (cif)
   );

   // ***************************************************************
   // Control fields
   // ***************************************************************
   // A power-related reset stops the watchdog; its own reset does not
   always_ff @(posedge ref_clk)
   begin
      if (pwr_rst)
         run_reg <= 1'b0;
      else if (wr_hit)
         run_reg <= reg_wdata[RUN_BIT];
   end

   always_ff @(posedge ref_clk)
   begin
      if (pwr_rst)
         sel_reg <= SEL_RESET;
      else if (wr_hit)
         sel_reg <= reg_wdata[SEL_HI_BIT:SEL_LO_BIT];
   end

   // Only an unlocked write may arm or disarm the reset path
   always_ff @(posedge ref_clk)
   begin
      if (pwr_rst)
         rsten_reg <= 1'b0;
      else if (prot_wr)
         rsten_reg <= reg_wdata[RSTEN_BIT];
   end

   // ***************************************************************
   // Time-out flag
   // ***************************************************************
   // A time-out landing on a software clear wins; resets beat both
   always_ff @(posedge ref_clk)
   begin
      if (any_rst || fire)
         flag_reg <= 1'b0;
      else if (cif.timeout)
         flag_reg <= 1'b1;
      else if (prot_wr)
         flag_reg <= reg_wdata[FLAG_BIT];
   end

   // ***************************************************************
   // Reset-cause flag
   // ***************************************************************
   // Frozen while the reset enable is low, software writes included
   always_ff @(posedge ref_clk)
   begin
      if (pwr_rst)
         cause_reg <= 1'b0;
      else if (rsten_reg)
      begin
         if (fire)
            cause_reg <= 1'b1;
         else if (wr_hit)
            cause_reg <= reg_wdata[CAUSE_BIT];
      end
   end

   // ***************************************************************
   // Restart handshake
   // ***************************************************************
   // The bit stays up until the counter has taken the restart and
   // then moved off zero; a slow RC clock keeps it up for a while.
   assign restart_done = restart_seen_reg && cif.count_nonzero;
   assign restart_take = prot_wr && reg_wdata[RESTART_BIT];

   always_ff @(posedge ref_clk)
   begin
      if (pwr_rst)
         restart_reg <= 1'b0;
      else if (restart_take)
         restart_reg <= 1'b1;
      else if (restart_done)
         restart_reg <= 1'b0;
   end

   // A second restart write re-arms the handshake from the start
   always_ff @(posedge ref_clk)
   begin
      if (pwr_rst)
         restart_seen_reg <= 1'b0;
      else if (restart_take)
         restart_seen_reg <= 1'b0;
      else if (cif.restart_ack)
         restart_seen_reg <= 1'b1;
      else if (restart_done)
         restart_seen_reg <= 1'b0;
   end

   // ***************************************************************
   // Grace window and reset sequencing
   // ***************************************************************
   // A restart taken on the very tick that ends the window still counts
   // as in time, so a pending request holds the reset off as well.
   assign grace_done = (phase_reg == WDT_GRACE) && wd_tick && run_reg
                       && (grace_reg == GRACE_LAST);
   assign fire = grace_done && rsten_reg && !cif.restart_ack
                 && !cif.restart_req;

   always_comb
   begin
      phase_next = phase_reg;
      unique case (phase_reg)
         WDT_COUNTING:
         begin
            if (cif.timeout)
               phase_next = WDT_GRACE;
         end
         WDT_GRACE:
         begin
            if (cif.restart_ack)
               phase_next = WDT_COUNTING;
            else if (fire)
               phase_next = WDT_RESETTING;
            else if (grace_done)
               phase_next = WDT_COUNTING;
         end
         WDT_RESETTING:
         begin
            if (hold_reg == HOLD_LAST)
               phase_next = WDT_COUNTING;
         end
         // The unused code falls back to counting instead of locking up
         default:
            phase_next = WDT_COUNTING;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (pwr_rst)
         phase_reg <= WDT_COUNTING;
      else
         phase_reg <= phase_next;
   end

   // Grace counts watchdog clocks, not ref_clk cycles
   always_ff @(posedge ref_clk)
   begin
      if (pwr_rst || phase_reg != WDT_GRACE)
         grace_reg <= '0;
      else if (wd_tick && run_reg)
         grace_reg <= grace_reg + GRACE_W'(1);
   end

   // The count is held at zero for the whole pulse, then runs again.
   // Eight bits of hold count limit MC_CLKS to at most 128 clocks.
   always_ff @(posedge ref_clk)
   begin
      if (pwr_rst || phase_reg != WDT_RESETTING)
         hold_reg <= '0;
      else
         hold_reg <= hold_reg + HOLD_W'(1);
   end

   always_ff @(posedge ref_clk)
   begin
      if (pwr_rst)
         sys_reset_reg <= 1'b0;
      else
         sys_reset_reg <= (phase_next == WDT_RESETTING);
   end

   // ***************************************************************
   // Interrupt request
   // ***************************************************************
   // Raised whatever the reset enable; a fired reset drops it along with the flag
   // Registered so the pin cannot glitch while flag and enables settle
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         irq_reg <= 1'b0;
      else
         irq_reg <= flag_reg && wdt_irq_enable
                    && global_irq_enable;
   end

   // ***************************************************************
   // Register read
   // ***************************************************************
   always_comb
   begin
      status_byte              = DATA_ZERO;
      status_byte[RUN_BIT]     = run_reg;
      status_byte[SEL_HI_BIT]  = sel_reg[1];
      status_byte[SEL_LO_BIT]  = sel_reg[0];
      status_byte[FLAG_BIT]    = flag_reg;
      status_byte[CAUSE_BIT]   = cause_reg;
      status_byte[RSTEN_BIT]   = rsten_reg;
      status_byte[RESTART_BIT] = restart_reg;
   end

   // Data is valid only in the cycle after the strobe
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         rdata_reg <= DATA_ZERO;
      else if (rd_hit)
         rdata_reg <= status_byte;
      else
         rdata_reg <= DATA_ZERO;
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign reg_rdata     = rdata_reg;
   assign wdt_irq       = irq_reg;
   assign wdt_sys_reset = sys_reset_reg;

endmodule : wdt_top

// >>> tb/wdt_top_checker.sv
`timescale 1ns/1ps
module wdt_top_checker
   import wdt_pkg::*;
#(
   parameter int unsigned MC_CLKS = 4
)
(
   // Clock and reset
   input wire logic              ref_clk,
   input wire logic              rst,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   // Interrupt
   input wire logic              wdt_irq_enable,
   input wire logic              global_irq_enable,
   input wire logic              wdt_irq,
   // Reset sources and output
   input wire logic              power_fail_rst,
   input wire logic              ext_rst,
   input wire logic              wdt_sys_reset
);
   // ***************************************************************
   // Reset pulse length
   // ***************************************************************
   logic [7:0] hi_cnt_reg;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         hi_cnt_reg <= 8'h00;
      else if (wdt_sys_reset)
         hi_cnt_reg <= hi_cnt_reg + 8'h01;
      else
         hi_cnt_reg <= 8'h00;
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // ***************************************************************
   // Properties
   // ***************************************************************
   rst_quiet_a:
   assert property ($fell(rst) |-> !wdt_sys_reset && !wdt_irq
                    && reg_rdata == DATA_ZERO)
      else $error("outputs active right after reset");
   rdata_idle_a:
   assert property (!$past(reg_rd) |-> reg_rdata == DATA_ZERO)
      else $error("read data outside its cycle");
   unmapped_rd_a:
   assert property ($past(reg_rd) && $past(reg_addr) != CTRL_ADDR
                    |-> reg_rdata == DATA_ZERO)
      else $error("unmapped read not zero");
   rsvd_bit_a:
   assert property (reg_rdata[6] == 1'b0)
      else $error("reserved bit read as one");
   irq_gate_a:
   assert property (!($past(wdt_irq_enable) && $past(global_irq_enable))
                    |-> !wdt_irq)
      else $error("interrupt without both enables");
   irq_clear_a:
   assert property (power_fail_rst || ext_rst |-> ##2 !wdt_irq)
      else $error("interrupt survives a reset source");
   sysrst_len_a:
   assert property ($fell(wdt_sys_reset) |-> hi_cnt_reg == 8'(2*MC_CLKS))
      else $error("system reset pulse length wrong");
   sysrst_gap_a:
   assert property ($fell(wdt_sys_reset) |-> !wdt_sys_reset [*8])
      else $error("system reset repeats at once");
endmodule : wdt_top_checker

bind wdt_top wdt_top_checker #(.MC_CLKS(MC_CLKS)) wdt_top_checker_inst
(
   .ref_clk           (ref_clk),
   .rst               (rst),
   .reg_addr          (reg_addr),
   .reg_rd            (reg_rd),
   .reg_rdata         (reg_rdata),
   .wdt_irq_enable    (wdt_irq_enable),
   .global_irq_enable (global_irq_enable),
   .wdt_irq           (wdt_irq),
   .power_fail_rst    (power_fail_rst),
   .ext_rst           (ext_rst),
   .wdt_sys_reset     (wdt_sys_reset)
);

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   import wdt_pkg::*;
   localparam int unsigned MC  = 4;
   localparam int unsigned IVL = 131072;
   logic              ref_clk;
   logic              rst;
   logic              reg_wr;
   logic              reg_rd;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic [DATA_W-1:0] reg_rdata;
   logic              sel_cpu;
   logic              rc_pin;
   logic              ta_open;
   logic              irq_en;
   logic              gie;
   logic              wdt_irq;
   logic              pf_rst;
   logic              x_rst;
   logic              sys_rst;
   int                error_cnt;
   int                n_tests;
   int                rc_div;

   wdt_top #(.MC_CLKS(MC)) wdt_top_inst
   (
      .ref_clk                     (ref_clk),
      .rst                         (rst),
      .reg_addr                    (reg_addr),
      .reg_wdata                   (reg_wdata),
      .reg_wr                      (reg_wr),
      .reg_rd                      (reg_rd),
      .reg_rdata                   (reg_rdata),
      .counter_clock_source_select (sel_cpu),
      .rc_osc_pin                  (rc_pin),
      .timed_access_open           (ta_open),
      .wdt_irq_enable              (irq_en),
      .global_irq_enable           (gie),
      .wdt_irq                     (wdt_irq),
      .power_fail_rst              (pf_rst),
      .ext_rst                     (x_rst),
      .wdt_sys_reset               (sys_rst)
   );

   always #5 ref_clk = ~ref_clk;
   // Slow oscillator: one level change every 100 reference cycles
   always @(posedge ref_clk)
   begin
      if (rc_div == 99)
      begin
         rc_div <= 0;
         rc_pin <= ~rc_pin;
      end
      else
         rc_div <= rc_div + 1;
   end

   // ***************************************************************
   // Bus and compare tasks
   // ***************************************************************
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick

   task automatic chk8(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
      n_tests++;
      if (g !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk8

   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic ta);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      ta_open   <= ta;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr  <= 1'b0;
      ta_open <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask : rd

   task automatic results;
      $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic test_reset;
      logic [7:0] v;
      rd(CTRL_ADDR, v);
      chk8("ctrl after reset", 8'h00, v);
      rd(8'h5a, v);
      chk8("unmapped read", 8'h00, v);
      $display("test_reset done");
   endtask : test_reset

   task automatic test_access;
      // Upper byte is written, lower byte is expected; first write locked
      logic [15:0] acc [7];
      logic [7:0]  v;
      acc = '{16'hb2b0, 16'h3232, 16'h3636, 16'h3232, 16'h3030,
              16'h3430, 16'h0808};
      for (int i = 0; i < 7; i++)
      begin
         wr(CTRL_ADDR, acc[i][15:8], i != 0);
         rd(CTRL_ADDR, v);
         chk8("ctrl write", acc[i][7:0], v);
      end
      wr(8'h01, 8'hff, 1'b1);
      rd(CTRL_ADDR, v);
      chk8("unmapped write", 8'h08, v);
      @(posedge ref_clk);
      irq_en <= 1'b1;
      gie    <= 1'b1;
      tick(3);
      chk8("irq both on", 8'h01, {7'h0, wdt_irq});
      @(posedge ref_clk);
      gie <= 1'b0;
      tick(3);
      chk8("irq global off", 8'h00, {7'h0, wdt_irq});
      @(posedge ref_clk);
      gie    <= 1'b1;
      irq_en <= 1'b0;
      tick(3);
      chk8("irq own off", 8'h00, {7'h0, wdt_irq});
      @(posedge ref_clk);
      irq_en <= 1'b1;
      x_rst  <= 1'b1;
      @(posedge ref_clk);
      x_rst <= 1'b0;
      rd(CTRL_ADDR, v);
      chk8("flag after ext reset", 8'h00, v);
      $display("test_access done");
   endtask : test_access

   task automatic test_restart;
      logic [7:0] v;
      int         i;
      @(posedge ref_clk);
      sel_cpu <= 1'b0;
      wr(CTRL_ADDR, 8'h01, 1'b1);
      rd(CTRL_ADDR, v);
      chk8("restart set", 8'h01, v);
      tick(600);
      rd(CTRL_ADDR, v);
      chk8("restart held, stopped", 8'h01, v);
      wr(CTRL_ADDR, 8'h80, 1'b0);
      for (i = 0; i < 200 && v[0] !== 1'b0; i++)
      begin
         tick(10);
         rd(CTRL_ADDR, v);
      end
      chk8("restart cleared", 8'h80, v);
      $display("test_restart done");
   endtask : test_restart

   task automatic test_timeout;
      logic [7:0] v;
      int         i;
      int         k;
      @(posedge ref_clk);
      sel_cpu <= 1'b1;
      wr(CTRL_ADDR, 8'h83, 1'b1);
      tick(IVL - 40);
      rd(CTRL_ADDR, v);
      chk8("before time-out", 8'h82, v);
      for (i = 0; i < 100 && wdt_irq !== 1'b1; i++)
         tick(1);
      chk8("irq at time-out", 8'h01, {7'h0, wdt_irq});
      rd(CTRL_ADDR, v);
      chk8("flag at time-out", 8'h8a, v);
      tick(400);
      chk8("no early reset", 8'h00, {7'h0, sys_rst});
      for (i = 0; i < 200 && sys_rst !== 1'b1; i++)
         tick(1);
      k = 402 + i;
      chk8("grace length", 8'h01, {7'h0, k >= 500 && k <= 520});
      tick(12);
      rd(CTRL_ADDR, v);
      chk8("after own reset", 8'h86, v);
      chk8("irq after own reset", 8'h00, {7'h0, wdt_irq});
      $display("test_timeout done");
   endtask : test_timeout

   task automatic test_power_fail;
      logic [7:0] v;
      @(posedge ref_clk);
      pf_rst <= 1'b1;
      @(posedge ref_clk);
      pf_rst <= 1'b0;
      rd(CTRL_ADDR, v);
      chk8("after power fail", 8'h00, v);
      $display("test_power_fail done");
   endtask : test_power_fail

   // ***************************************************************
   // Main sequence and watchdog
   // ***************************************************************
   initial
   begin
      ref_clk   = 1'b0;
      rc_pin    = 1'b0;
      rc_div    = 0;
      rst       = 1'b1;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      sel_cpu   = 1'b1;
      ta_open   = 1'b0;
      irq_en    = 1'b0;
      gie       = 1'b0;
      pf_rst    = 1'b0;
      x_rst     = 1'b0;
      error_cnt = 0;
      n_tests   = 0;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      test_reset();
      test_access();
      test_restart();
      test_timeout();
      test_power_fail();
      results();
   end

   // The single long interval dominates the run time
   initial
   begin
      #(10 * (IVL + 20000));
      error_cnt++;
      results();
   end
endmodule : testbench
